/* hw/pbrst_pkg.sv */
// constants and carrier types of the pushbutton and power-fail reset supervisor
// What this block does
// - while the supply is flagged as failed, the reset pin is actively driven low.
// - after the supply recovers, the pin stays low for the reset active time, then is released.
// - the reset pin is watched as a pushbutton input and debounced over the debounce interval.
// - an accepted pushbutton press drives the reset pin low for the reset active time, or one cycle with the oscillator disabled or stopped.
// - with the oscillator-disable bit at 1, recovery is skipped and the pin is released at once.
// - the recovery delay applies only while the oscillator is enabled and running.
package pbrst_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  // both intervals are 250 ms; counts are derived so the rate can change in one place
  localparam int unsigned RESET_ACTIVE_MS = 250;
  localparam int unsigned DEBOUNCE_MS = 250;
  localparam int unsigned RESET_ACTIVE_CYC = (CLK_HZ / 1000) * RESET_ACTIVE_MS;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int unsigned CNT_W = 24;

  typedef enum logic [1:0] {
    PBRST_FAIL,
    PBRST_HOLD,
    PBRST_IDLE,
    PBRST_PRESS
  } pbrst_state_e;

  // open-drain reset pin: data level and output enable
  typedef struct packed {
    logic drv_o;
    logic oe;
  } pbrst_pin_s;
endpackage

/* hw/pbrst_supervisor.sv */
// reset supervisor: power-fail hold, recovery delay and pushbutton debounce on one pin
`timescale 1ns/1ps
module pbrst_supervisor #(
  parameter int unsigned RESET_ACTIVE_CYC = pbrst_pkg::RESET_ACTIVE_CYC,
  parameter int unsigned DEBOUNCE_CYC = pbrst_pkg::DEBOUNCE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic power_fail_i,
  input wire logic oscillator_disable_bit_i,
  input wire logic osc_running_i,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic reset_active_o,
  output logic press_seen_o
);
  localparam logic [pbrst_pkg::CNT_W-1:0] HOLD_LAST =
    pbrst_pkg::CNT_W'(RESET_ACTIVE_CYC - 1);
  localparam logic [pbrst_pkg::CNT_W-1:0] DB_LAST = pbrst_pkg::CNT_W'(DEBOUNCE_CYC - 1);
  localparam logic [pbrst_pkg::CNT_W-1:0] CNT_ZERO = '0;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pf_sync_q;
  logic [1:0] pin_sync_q;
  logic [1:0] osc_sync_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // power-fail assumed present at reset so the pin starts low
      pf_sync_q <= 2'h3;
      pin_sync_q <= 2'h3;
      osc_sync_q <= 2'h0;
    end else if (clk_en_i) begin
      pf_sync_q <= {pf_sync_q[0], power_fail_i};
      pin_sync_q <= {pin_sync_q[0], rst_pin_i};
      osc_sync_q <= {osc_sync_q[0], osc_running_i};
    end
  end
  logic pf_s;
  logic pin_low_s;
  logic osc_s;
  assign pf_s = pf_sync_q[1];
  assign pin_low_s = ~pin_sync_q[1];
  assign osc_s = osc_sync_q[1];

  // recovery delay only when oscillator is enabled and running
  logic delay_en;
  assign delay_en = !oscillator_disable_bit_i && osc_s;

  // ----------------------------------------------------------------
  // pin watch blanking
  // ----------------------------------------------------------------
  // the sensed pin lags our own drive by the oe register and the two
  // sync stages, so the tail of our own low would look like a press;
  // with a short debounce that would retrigger the reset forever
  logic oe_q;
  logic [1:0] drv_hist_q;
  logic watch_ok;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_hist_q <= '1;
    end else if (clk_en_i) begin
      drv_hist_q <= {drv_hist_q[0], oe_q};
    end
  end
  assign watch_ok = !oe_q && (drv_hist_q == '0);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  pbrst_pkg::pbrst_state_e state_q;
  logic [pbrst_pkg::CNT_W-1:0] cnt_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= pbrst_pkg::PBRST_FAIL;
      cnt_q <= CNT_ZERO;
    end else if (clk_en_i) begin
      if (pf_s) begin
        state_q <= pbrst_pkg::PBRST_FAIL;
        cnt_q <= CNT_ZERO;
      end else begin
        case (state_q)
          pbrst_pkg::PBRST_FAIL: begin
            cnt_q <= CNT_ZERO;
            state_q <= delay_en ? pbrst_pkg::PBRST_HOLD : pbrst_pkg::PBRST_IDLE;
          end
          pbrst_pkg::PBRST_HOLD: begin
            // disabling the oscillator mid-hold releases at once as well
            if (!delay_en || cnt_q == HOLD_LAST) begin
              state_q <= pbrst_pkg::PBRST_IDLE;
              cnt_q <= CNT_ZERO;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          pbrst_pkg::PBRST_IDLE: begin
            cnt_q <= CNT_ZERO;
            // only a pin that we are not pulling low ourselves can start a press
            if (pin_low_s && watch_ok) begin
              state_q <= pbrst_pkg::PBRST_PRESS;
            end
          end
          pbrst_pkg::PBRST_PRESS: begin
            if (!pin_low_s) begin
              // a bounce restarts the whole interval
              state_q <= pbrst_pkg::PBRST_IDLE;
              cnt_q <= CNT_ZERO;
            end else if (cnt_q == DB_LAST) begin
              state_q <= pbrst_pkg::PBRST_HOLD;
              cnt_q <= CNT_ZERO;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          default: begin
            state_q <= pbrst_pkg::PBRST_FAIL;
            cnt_q <= CNT_ZERO;
          end
        endcase
      end
    end
  end

  logic drive_low;
  assign drive_low = (state_q == pbrst_pkg::PBRST_FAIL) || (state_q == pbrst_pkg::PBRST_HOLD);

  // ----------------------------------------------------------------
  // pin drive; only resets the host, nothing else in the device is touched
  // ----------------------------------------------------------------
  logic press_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_q <= 1'b1;
      press_q <= 1'b0;
    end else if (clk_en_i) begin
      oe_q <= drive_low;
      press_q <= (state_q == pbrst_pkg::PBRST_PRESS) && !pf_s && pin_low_s && cnt_q == DB_LAST;
    end
  end
  // data level is always low; the enable alone decides the pin
  pbrst_pkg::pbrst_pin_s pin_drv;
  assign pin_drv = '{drv_o: 1'b0, oe: oe_q};
  assign rst_pin_o = pin_drv.drv_o;
  assign rst_pin_oe_o = pin_drv.oe;
  assign reset_active_o = oe_q;
  assign press_seen_o = press_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // oe is registered from the state, so pin checks look one enabled edge past it
  sequence s_fail;
    pf_s;
  endsequence
  sequence s_recovered;
    !pf_s && $past(pf_s);
  endsequence
  // a press completes when the last debounce count still sees the pin low
  sequence s_press_done;
    clk_en_i && !pf_s && state_q == pbrst_pkg::PBRST_PRESS && pin_low_s && cnt_q == DB_LAST;
  endsequence

  chk_fail_drives_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_en_i and s_fail) ##1 clk_en_i |=> rst_pin_oe_o)
    else $error("pin not driven during power fail");
  chk_hold_after_recover: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ((clk_en_i && delay_en) and s_recovered) ##1 (clk_en_i && !pf_s && delay_en)[*2]
      |=> rst_pin_oe_o)
    else $error("pin released too early after recovery");
  chk_bypass_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_q == pbrst_pkg::PBRST_FAIL && !pf_s && !delay_en
      |=> state_q == pbrst_pkg::PBRST_IDLE)
    else $error("bypass did not release at once");
  chk_hold_len: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_q == pbrst_pkg::PBRST_HOLD |-> cnt_q <= HOLD_LAST)
    else $error("hold count beyond the active time");
  chk_press_gives_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_press_done
      |=> ((state_q == pbrst_pkg::PBRST_HOLD) and (clk_en_i |=> rst_pin_oe_o)))
    else $error("accepted press did not assert reset");
  chk_bounce_restart: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !pf_s && state_q == pbrst_pkg::PBRST_PRESS && !pin_low_s
      |=> state_q == pbrst_pkg::PBRST_IDLE && cnt_q == CNT_ZERO)
    else $error("bounce did not restart debounce");
  chk_debounce_count: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !pf_s && state_q == pbrst_pkg::PBRST_PRESS && pin_low_s && cnt_q < DB_LAST
      |=> state_q == pbrst_pkg::PBRST_PRESS && cnt_q == $past(cnt_q) + 1'b1)
    else $error("debounce count did not advance");
  chk_freeze: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !clk_en_i |=> $stable(state_q) && $stable(cnt_q) && $stable(rst_pin_oe_o))
    else $error("state moved while clock enable low");

  // each antecedent names the clock enable that its step needs
  chk_fail_state: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && pf_s |=> state_q == pbrst_pkg::PBRST_FAIL)
    else $error("power fail did not force the fail state");

  chk_idle_released: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && state_q == pbrst_pkg::PBRST_IDLE |=> !rst_pin_oe_o)
    else $error("pin still driven while idle");

  chk_osc_stop_cut: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !pf_s && state_q == pbrst_pkg::PBRST_HOLD && !delay_en
      |=> state_q == pbrst_pkg::PBRST_IDLE)
    else $error("hold kept without a running oscillator");

  chk_no_self_press: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !pf_s && state_q == pbrst_pkg::PBRST_IDLE && !watch_ok
      |=> state_q == pbrst_pkg::PBRST_IDLE)
    else $error("own drive taken as a press");

  chk_high_pin_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && !pf_s && state_q == pbrst_pkg::PBRST_IDLE && !pin_low_s
      |=> state_q == pbrst_pkg::PBRST_IDLE)
    else $error("press started with the pin high");

  chk_press_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && press_seen_o |=> !press_seen_o)
    else $error("press indication longer than one cycle");
endmodule

/* tb/pbrst_button_model.sv */
// pushbutton and internal pullup on the open-drain reset pin
`timescale 1ns/1ps
module pbrst_button_model (
  input wire logic oe_i,
  input wire logic drv_i,
  input wire logic pressed_i,
  output logic pin_level_o
);
  // the pullup wins unless the block or the button sinks the pin
  assign pin_level_o = ((oe_i && !drv_i) || pressed_i) ? 1'b0 : 1'b1;
endmodule

/* tb/pushbutton_power_fail_reset_bench.sv */
// self-checking bench of the reset supervisor
`timescale 1ns/1ps
`define CHK(g, e) begin @(negedge core_clk_i); n_tests++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pushbutton_power_fail_reset_bench;
  logic core_clk_i = 1'b0;
  logic rst_n_i, clk_en_i, power_fail_i, dis, run, pressed, pin;
  logic pin_o, oe, act, seen;
  int fail_count = 0, n_tests = 0, cycles = 0, press_cnt = 0, p0;
  always #25 core_clk_i = ~core_clk_i;
  // short counts keep the run brief; margins below are derived from 20 and 10
  pbrst_supervisor #(.RESET_ACTIVE_CYC(20), .DEBOUNCE_CYC(10)) DUT (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .power_fail_i(power_fail_i),
    .oscillator_disable_bit_i(dis), .osc_running_i(run), .rst_pin_i(pin),
    .rst_pin_o(pin_o), .rst_pin_oe_o(oe), .reset_active_o(act), .press_seen_o(seen));
  pbrst_button_model model (.oe_i(oe), .drv_i(pin_o), .pressed_i(pressed), .pin_level_o(pin));
  always @(posedge core_clk_i) begin
    if (seen === 1'b1) press_cnt++;
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      summarize();
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task t_recover;
    cyc(18); `CHK(oe, 1'b1)
    `CHK(act, 1'b1)
    `CHK(pin, 1'b0)
    cyc(10); `CHK(oe, 1'b0)
    `CHK(act, 1'b0)
    `CHK(pin, 1'b1)
    `CHK(pin_o, 1'b0)
  endtask
  task t_fail;
    @(posedge core_clk_i) power_fail_i <= 1'b1;
    cyc(4); `CHK(oe, 1'b1)
    cyc(40); `CHK(oe, 1'b1)
    @(posedge core_clk_i) power_fail_i <= 1'b0;
    t_recover();
  endtask
  task t_bypass(input logic d, input logic r);
    @(posedge core_clk_i) begin
      dis <= d;
      run <= r;
      power_fail_i <= 1'b1;
    end
    cyc(6); `CHK(oe, 1'b1)
    @(posedge core_clk_i) power_fail_i <= 1'b0;
    // no recovery hold: the pin is free within the sync latency
    cyc(6); `CHK(oe, 1'b0)
    @(posedge core_clk_i) begin
      dis <= 1'b0;
      run <= 1'b1;
    end
    cyc(4);
  endtask
  task t_osc_cut;
    @(posedge core_clk_i) power_fail_i <= 1'b1;
    cyc(6);
    @(posedge core_clk_i) power_fail_i <= 1'b0;
    cyc(4); `CHK(oe, 1'b1)
    @(posedge core_clk_i) run <= 1'b0;
    // a full hold would still drive here; the stopped oscillator cuts it
    cyc(8); `CHK(oe, 1'b0)
    @(posedge core_clk_i) run <= 1'b1;
    cyc(4);
  endtask
  task t_freeze;
    @(posedge core_clk_i) power_fail_i <= 1'b1;
    cyc(6);
    @(posedge core_clk_i) power_fail_i <= 1'b0;
    cyc(6);
    @(posedge core_clk_i) clk_en_i <= 1'b0;
    // the hold counts enabled cycles only, so it outlasts the frozen span
    cyc(40); `CHK(oe, 1'b1)
    @(posedge core_clk_i) clk_en_i <= 1'b1;
    cyc(10); `CHK(oe, 1'b1)
    cyc(20); `CHK(oe, 1'b0)
  endtask
  task t_press(input int n, input int exp);
    p0 = press_cnt;
    @(posedge core_clk_i) pressed <= 1'b1;
    cyc(n);
    @(posedge core_clk_i) pressed <= 1'b0;
    cyc(4); `CHK(press_cnt - p0, exp)
    `CHK(oe, exp == 1)
    cyc(30); `CHK(oe, 1'b0)
  endtask
  initial begin
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    power_fail_i = 1'b0;
    dis = 1'b0;
    run = 1'b1;
    pressed = 1'b0;
    cyc(3); `CHK(oe, 1'b1)
    @(posedge core_clk_i) rst_n_i <= 1'b1;
    t_recover();
    t_fail();
    t_bypass(1'b1, 1'b1);
    t_bypass(1'b0, 1'b0);
    t_osc_cut();
    t_freeze();
    t_press(8, 0);
    t_press(15, 1);
    summarize();
  end
endmodule
